// ==== core/pcc_pkg.sv ====
// constants and types for the proximity calibration control block
package pcc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] PCC_ADDR_CALIB_CFG  = 8'hd9;
   localparam logic [7:0] PCC_ADDR_CALIB_SYNC = 8'hda;
   localparam logic [7:0] PCC_ADDR_CALIB_STAT = 8'hdc;
   localparam logic [7:0] PCC_ADDR_INTEN      = 8'hdd;
   localparam logic [7:0] PCC_CFG_RESET       = 8'h50;
   localparam logic [7:0] PCC_SYNC_RESET      = 8'h00;
   localparam logic [7:0] PCC_INTEN_RESET     = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int         PCC_CFG_AVG_LSB     = 0;
   localparam int         PCC_CFG_AUTO_BIT    = 3;
   localparam int         PCC_CFG_TARGET_LSB  = 5;
   localparam int         PCC_SYNC_ALL_BIT    = 0;
   localparam int         PCC_STAT_OFFDEC_BIT = 2;
   localparam int         PCC_STAT_DONE_BIT   = 0;
   localparam int         PCC_INT_STYLE_BIT   = 1;
   localparam logic [7:0] PCC_IRQ_EVENT_MASK  = 8'hfd;
   // ----------------------------------------
   // counts and widths
   // ----------------------------------------
   localparam logic [2:0] PCC_AVG_MAX_CODE    = 3'h4;
   localparam logic [3:0] PCC_CAL_LAST_CYCLE  = 4'h8;
   localparam logic [3:0] PCC_CAL_CYCLES      = 4'h9;
   localparam logic [8:0] PCC_CAL_FIRST_TRIAL = 9'h100;
   localparam logic [9:0] PCC_TARGET_BASE     = 10'h1ff;
   localparam int         PCC_RES_W           = 10;
   localparam int         PCC_OFF_W           = 9;
   localparam int         PCC_ACC_W           = 14;
   // ----------------------------------------
   // state types
   // ----------------------------------------
   typedef enum logic [2:0] {CS_IDLE, CS_MEAS, CS_WAIT_SYNC, CS_DELAY, CS_CAL_MEAS} pcc_cal_state_t;
   typedef enum logic [1:0] {AV_IDLE, AV_FIRE, AV_WAIT} pcc_avg_state_t;
endpackage : pcc_pkg

// ==== core/pcc_averager.sv ====
// sample averager: fires one emitter burst per sample and averages the results
`timescale 1ns/1ns
module pcc_averager
   import pcc_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // control
   input  wire logic                 start,
   input  wire logic [2:0]           avg_code,
   // sample engine
   output logic                      sample_start,
   input  wire logic                 sample_done,
   input  wire logic [PCC_RES_W-1:0] sample_value,
   // result
   output logic                      sample_zero,
   output logic                      result_valid,
   output logic [PCC_RES_W-1:0]      result
);
   pcc_avg_state_t         state, next_state;
   logic [PCC_ACC_W-1:0]   acc, next_acc, sum, shifted;
   logic [3:0]             left, next_left;
   logic [2:0]             shift;
   logic [PCC_RES_W-1:0]   next_result;
   logic                   next_valid;

   // ----------------------------------------
   // sample sequencing
   // ----------------------------------------
   // sample count select; reserved codes fall back to a single sample
   assign shift        = (avg_code <= PCC_AVG_MAX_CODE) ? avg_code : 3'h0;
   assign sample_start = (state == AV_FIRE);
   assign sample_zero  = (state == AV_WAIT) && sample_done && (sample_value == '0);
   assign sum          = acc + {{(PCC_ACC_W-PCC_RES_W){1'b0}}, sample_value};
   assign shifted      = sum >> shift;

   always_comb begin
      next_state  = state;
      next_acc    = acc;
      next_left   = left;
      next_result = result;
      next_valid  = 1'b0;
      case (state)
         AV_IDLE: begin
            if (start) begin
               next_acc   = '0;
               next_left  = 4'hf >> (3'h4 - shift);
               next_state = AV_FIRE;
            end
         end
         AV_FIRE: next_state = AV_WAIT;
         AV_WAIT: begin
            if (sample_done) begin
               // result only after the last sample is averaged
               if (left == 4'h0) begin
                  next_result = shifted[PCC_RES_W-1:0];
                  next_valid  = 1'b1;
                  next_state  = AV_IDLE;
               end else begin
                  next_acc   = sum;
                  next_left  = left - 4'h1;
                  next_state = AV_FIRE;
               end
            end
         end
         default: next_state = AV_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state        <= AV_IDLE;
         acc          <= '0;
         left         <= 4'h0;
         result       <= '0;
         result_valid <= 1'b0;
      end else begin
         state        <= next_state;
         acc          <= next_acc;
         left         <= next_left;
         result       <= next_result;
         result_valid <= next_valid;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [4:0] bursts;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bursts <= 5'h00;
      end else if (start && state == AV_IDLE) begin
         bursts <= 5'h00;
      end else if (sample_start) begin
         bursts <= bursts + 5'h01;
      end
   end

   avg_burst_count_a: assert property (@(posedge clk) disable iff (reset)
      result_valid |-> bursts == (5'h01 << $past(shift)))
      else $error("burst count does not match averaging select");
endmodule : pcc_averager

// ==== core/pcc_calib_ctrl.sv ====
// proximity calibration control: registers, calibration sequencer, offset lowering
//
// Operation
// - averaging select field 2:0 picks off, 2, 4, 8 or 16 samples, others reserved, reset 0.
// - each averaged sample fires its own emitter pulse burst.
// - the result register updates only once all samples are taken and averaged.
// - calibration trims the offset so an empty scene reads near the selected target count.
// - one calibration run is exactly nine measurement cycles.
// - with the all-cycles sync bit set, every cycle waits for a frame sync edge plus start delay.
// - with that bit clear and proximity frame sync on, only the first cycle is synced.
// - with both clear, all nine cycles run at once and frame sync is ignored.
// - status bit 2 sets when the offset is lowered automatically.
// - status bit 2 clears on a write of 1 or when auto lowering is disabled.
// - status bit 0 mirrors the calibration interrupt status bit.
// - interrupt enable bits 7,6,5,4,3,2,0 as listed, all reset 0.
// - interrupt enable bit 1 picks hysteresis (1) or level (0) proximity interrupts.
// - with auto lowering on, a zero ADC reading outside calibration lowers the offset unless the diode is off or the offset is 0.
`timescale 1ns/1ns
module pcc_calib_ctrl
   import pcc_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset,
   // register port
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic [7:0]                reg_rdata,
   // measurement control
   input  wire logic                 calib_start,
   input  wire logic                 meas_request,
   input  wire logic                 frame_sync,
   input  wire logic                 proximity_framesync_enable,
   input  wire logic [15:0]          proximity_start_delay,
   input  wire logic                 diode_enable,
   // sample engine
   output logic                      sample_start,
   input  wire logic                 sample_done,
   input  wire logic [PCC_RES_W-1:0] sample_value,
   // results and status
   output logic [PCC_RES_W-1:0]      proximity_result,
   output logic                      result_valid,
   output logic [PCC_OFF_W-1:0]      prox_offset,
   output logic                      calibrating,
   output logic                      calib_done_event,
   input  wire logic                 calibration_irq_status,
   // interrupt
   input  wire logic [7:0]           irq_events,
   output logic                      prox_irq_style_select,
   output logic                      irq_out
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0]            calibration_config, next_cfg;
   logic [7:0]            calibration_sync_config, next_sync;
   logic [7:0]            interrupt_enable_main, next_inten;
   logic                  offset_decremented_flag, next_flag;
   logic [7:0]            next_rdata;
   logic                  next_irq;
   pcc_cal_state_t        state, next_state;
   logic [3:0]            cycle, next_cycle;
   logic [15:0]           delay, next_delay;
   logic [PCC_OFF_W-1:0]  next_offset, trial;
   logic                  next_done;
   logic                  fs_prev, fs_rise;
   logic                  avg_start, avg_valid, avg_zero, auto_dec;
   logic [PCC_RES_W-1:0]  avg_result, target;
   logic [2:0]            sample_average_select, calib_result_target;
   logic                  auto_offset_lowering_enable, calib_all_cycles_framesync;
   logic                  calibration_done_flag;
   logic                  wr_cfg, wr_stat;

   assign sample_average_select       = calibration_config[PCC_CFG_AVG_LSB +: 3];
   assign calib_result_target         = calibration_config[PCC_CFG_TARGET_LSB +: 3];
   assign auto_offset_lowering_enable = calibration_config[PCC_CFG_AUTO_BIT];
   assign calib_all_cycles_framesync  = calibration_sync_config[PCC_SYNC_ALL_BIT];
   // interrupt style straight from the enable register
   assign prox_irq_style_select       = interrupt_enable_main[PCC_INT_STYLE_BIT];
   // done flag is a live copy, so clearing the source clears it too
   assign calibration_done_flag       = calibration_irq_status;
   assign wr_cfg                      = reg_write && (reg_addr == PCC_ADDR_CALIB_CFG);
   assign wr_stat                     = reg_write && (reg_addr == PCC_ADDR_CALIB_STAT);
   assign target                      = PCC_TARGET_BASE >> (3'h7 - calib_result_target);
   assign trial                       = PCC_CAL_FIRST_TRIAL >> cycle;
   assign fs_rise                     = frame_sync && !fs_prev;
   assign calibrating                 = (state == CS_WAIT_SYNC) || (state == CS_DELAY) || (state == CS_CAL_MEAS);
   assign result_valid                = avg_valid;
   // lowering only outside calibration and only with the diode on
   assign auto_dec = avg_zero && (state == CS_MEAS) && auto_offset_lowering_enable && diode_enable
                     && (prox_offset != '0);

   // ----------------------------------------
   // averager
   // ----------------------------------------
   pcc_averager u_avg (
      .clk          (clk),
      .reset        (reset),
      .start        (avg_start),
      .avg_code     (sample_average_select),
      .sample_start (sample_start),
      .sample_done  (sample_done),
      .sample_value (sample_value),
      .sample_zero  (avg_zero),
      .result_valid (avg_valid),
      .result       (avg_result)
   );

   // ----------------------------------------
   // calibration sequencer
   // ----------------------------------------
   always_comb begin
      next_state  = state;
      next_cycle  = cycle;
      next_delay  = delay;
      next_offset = prox_offset;
      next_done   = 1'b0;
      avg_start   = 1'b0;
      case (state)
         CS_IDLE: begin
            if (calib_start) begin
               next_cycle  = 4'h0;
               next_offset = PCC_CAL_FIRST_TRIAL;
               // first cycle synced when either sync control is set
               if (calib_all_cycles_framesync || proximity_framesync_enable) begin
                  next_state = CS_WAIT_SYNC;
               end else begin
                  avg_start  = 1'b1;
                  next_state = CS_CAL_MEAS;
               end
            end else if (meas_request) begin
               avg_start  = 1'b1;
               next_state = CS_MEAS;
            end
         end
         CS_MEAS: begin
            // zero reading lowers the offset by one step
            if (auto_dec) begin
               next_offset = prox_offset - 9'h001;
            end
            if (avg_valid) begin
               next_state = CS_IDLE;
            end
         end
         CS_WAIT_SYNC: begin
            if (fs_rise) begin
               next_delay = proximity_start_delay;
               next_state = CS_DELAY;
            end
         end
         CS_DELAY: begin
            if (delay == 16'h0000) begin
               avg_start  = 1'b1;
               next_state = CS_CAL_MEAS;
            end else begin
               next_delay = delay - 16'h0001;
            end
         end
         CS_CAL_MEAS: begin
            if (avg_valid) begin
               // binary search: too low a reading means too much offset
               if (avg_result < target) begin
                  next_offset = prox_offset & ~trial;
               end
               if (cycle == PCC_CAL_LAST_CYCLE) begin
                  next_done  = 1'b1;
                  next_state = CS_IDLE;
               end else begin
                  next_cycle  = cycle + 4'h1;
                  next_offset = next_offset | (trial >> 1);
                  // every cycle synced; later cycles back to back
                  if (calib_all_cycles_framesync) begin
                     next_state = CS_WAIT_SYNC;
                  end else begin
                     avg_start = 1'b1;
                  end
               end
            end
         end
         default: next_state = CS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state            <= CS_IDLE;
         cycle            <= 4'h0;
         delay            <= 16'h0000;
         prox_offset      <= '0;
         calib_done_event <= 1'b0;
         fs_prev          <= 1'b0;
         proximity_result <= '0;
      end else begin
         state            <= next_state;
         cycle            <= next_cycle;
         delay            <= next_delay;
         prox_offset      <= next_offset;
         calib_done_event <= next_done;
         fs_prev          <= frame_sync;
         if (avg_valid) begin
            proximity_result <= avg_result;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_comb begin
      next_cfg   = calibration_config;
      next_sync  = calibration_sync_config;
      next_inten = interrupt_enable_main;
      next_flag  = offset_decremented_flag;
      next_rdata = reg_rdata;
      // reserved bits are stored as written; software keeps them at default
      if (wr_cfg) begin
         next_cfg = reg_wdata;
      end
      if (reg_write && reg_addr == PCC_ADDR_CALIB_SYNC) begin
         next_sync = reg_wdata;
      end
      if (reg_write && reg_addr == PCC_ADDR_INTEN) begin
         next_inten = reg_wdata;
      end
      // clear by writing one or by dropping the enable
      if ((wr_stat && reg_wdata[PCC_STAT_OFFDEC_BIT]) || (wr_cfg && !reg_wdata[PCC_CFG_AUTO_BIT])) begin
         next_flag = 1'b0;
      end
      // a lowering in the same cycle beats the clear
      if (auto_dec) begin
         next_flag = 1'b1;
      end
      if (reg_read) begin
         case (reg_addr)
            PCC_ADDR_CALIB_CFG:  next_rdata = calibration_config;
            PCC_ADDR_CALIB_SYNC: next_rdata = calibration_sync_config;
            PCC_ADDR_CALIB_STAT: next_rdata = {5'h00, offset_decremented_flag, 1'b0, calibration_done_flag};
            PCC_ADDR_INTEN:      next_rdata = interrupt_enable_main;
            default:             next_rdata = 8'h00;
         endcase
      end
      // enabled pending event drives the line, style bit excluded
      next_irq = |(irq_events & interrupt_enable_main & PCC_IRQ_EVENT_MASK);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         calibration_config      <= PCC_CFG_RESET;
         calibration_sync_config <= PCC_SYNC_RESET;
         interrupt_enable_main   <= PCC_INTEN_RESET;
         offset_decremented_flag <= 1'b0;
         reg_rdata               <= 8'h00;
         irq_out                 <= 1'b0;
      end else begin
         calibration_config      <= next_cfg;
         calibration_sync_config <= next_sync;
         interrupt_enable_main   <= next_inten;
         offset_decremented_flag <= next_flag;
         reg_rdata               <= next_rdata;
         irq_out                 <= next_irq;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [3:0] cal_launches;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cal_launches <= 4'h0;
      end else if (state == CS_IDLE) begin
         // an unsynced run launches its first cycle straight from idle
         cal_launches <= {3'h0, avg_start && calib_start};
      end else if (avg_start) begin
         cal_launches <= cal_launches + 4'h1;
      end
   end

   result_forward_a: assert property (@(posedge clk) disable iff (reset)
      $changed(proximity_result) |-> $past(avg_valid))
      else $error("result changed without a finished average");
   nine_cycles_a: assert property (@(posedge clk) disable iff (reset)
      calib_done_event |-> $past(cal_launches) == PCC_CAL_CYCLES)
      else $error("calibration run was not nine cycles");
   sync_every_a: assert property (@(posedge clk) disable iff (reset)
      (avg_start && calibrating && calib_all_cycles_framesync) |-> state == CS_DELAY)
      else $error("calibration cycle started without frame sync");
   sync_first_a: assert property (@(posedge clk) disable iff (reset)
      (avg_start && state == CS_CAL_MEAS && !calib_all_cycles_framesync) |=> state == CS_CAL_MEAS)
      else $error("later calibration cycle did not run back to back");
   no_sync_a: assert property (@(posedge clk) disable iff (reset)
      (state == CS_IDLE && calib_start && !calib_all_cycles_framesync && !proximity_framesync_enable)
      |-> avg_start ##1 state == CS_CAL_MEAS)
      else $error("unsynced calibration waited for frame sync");
   offdec_set_a: assert property (@(posedge clk) disable iff (reset)
      auto_dec |=> offset_decremented_flag && prox_offset == $past(prox_offset) - 9'h001)
      else $error("offset lowering not flagged");
   offdec_clear_a: assert property (@(posedge clk) disable iff (reset)
      (wr_stat && reg_wdata[PCC_STAT_OFFDEC_BIT] && !auto_dec) |=> !offset_decremented_flag)
      else $error("offset flag did not clear");
   done_mirror_a: assert property (@(posedge clk) disable iff (reset)
      (reg_read && reg_addr == PCC_ADDR_CALIB_STAT) |=> reg_rdata[PCC_STAT_DONE_BIT] == $past(calibration_irq_status))
      else $error("done flag does not mirror interrupt status");
   lower_gate_a: assert property (@(posedge clk) disable iff (reset)
      (avg_zero && (!diode_enable || !auto_offset_lowering_enable)) |=> prox_offset == $past(prox_offset))
      else $error("offset lowered while disabled");
   irq_gate_a: assert property (@(posedge clk) disable iff (reset)
      irq_out |-> ($past(irq_events) & $past(interrupt_enable_main) & PCC_IRQ_EVENT_MASK) != 8'h00)
      else $error("interrupt without enabled pending event");

   cal_synced_c: cover property (@(posedge clk) disable iff (reset)
      calib_done_event && calib_all_cycles_framesync);
   cal_free_c: cover property (@(posedge clk) disable iff (reset)
      calib_done_event && !calib_all_cycles_framesync && !proximity_framesync_enable);
   auto_lower_c: cover property (@(posedge clk) disable iff (reset) auto_dec);
   avg_result_c: cover property (@(posedge clk) disable iff (reset)
      avg_valid && state == CS_MEAS && sample_average_select == PCC_AVG_MAX_CODE);
endmodule : pcc_calib_ctrl

// ==== tb/pcc_sample_model.sv ====
// sample engine model answering each sample request after a short conversion
`timescale 1ns/1ns
module pcc_sample_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // sample engine
   input  wire logic       sample_start,
   input  wire logic [9:0] level,
   output logic            sample_done,
   output logic [9:0]      sample_value
);
   logic [1:0] wait_cnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_cnt <= 2'h0;
      end else if (sample_start) begin
         wait_cnt <= 2'h2;
      end else if (wait_cnt != 2'h0) begin
         wait_cnt <= wait_cnt - 2'h1;
      end
   end
   assign sample_done  = (wait_cnt == 2'h1);
   // value garbled outside done, so a late capture shows up
   assign sample_value = sample_done ? level : ~level;
endmodule : pcc_sample_model

// ==== tb/testbench.sv ====
// self-checking bench for the proximity calibration control block
`timescale 1ns/1ns
module testbench;
   import pcc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       clk, reset, reg_write, reg_read, calib_start, meas_request, frame_sync;
   logic       pfs_en, diode_enable, sample_start, sample_done, result_valid, calibrating;
   logic       calib_done_event, cal_irq, style, irq_out, fs_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_events;
   logic [9:0] level, sample_value, proximity_result;
   logic [8:0] prox_offset;
   int         err_total, compares, samp_cnt, fs_cnt, s0, cyc;
   pcc_calib_ctrl u_pcc_calib_ctrl (.clk(clk), .reset(reset), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .calib_start(calib_start), .meas_request(meas_request), .frame_sync(frame_sync),
      .proximity_framesync_enable(pfs_en), .proximity_start_delay(16'h0003),
      .diode_enable(diode_enable), .sample_start(sample_start), .sample_done(sample_done),
      .sample_value(sample_value), .proximity_result(proximity_result), .result_valid(result_valid),
      .prox_offset(prox_offset), .calibrating(calibrating), .calib_done_event(calib_done_event),
      .calibration_irq_status(cal_irq), .irq_events(irq_events), .prox_irq_style_select(style),
      .irq_out(irq_out));
   pcc_sample_model u_pcc_sample_model (.clk(clk), .reset(reset), .sample_start(sample_start),
      .level(level), .sample_done(sample_done), .sample_value(sample_value));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // frames every 40 cycles while enabled
   always @(posedge clk) begin
      samp_cnt   <= samp_cnt + int'(sample_start);
      fs_cnt     <= fs_en ? fs_cnt + 1 : 0;
      frame_sync <= fs_en && (fs_cnt % 40 < 2);
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, e}, what);
   endtask : rd
   task wait_on(input bit done_ev);
      cyc = 0;
      while (cyc < 1000 && (done_ev ? calib_done_event : result_valid) !== 1'b1) begin
         @(posedge clk);
         #1;
         cyc++;
      end
      chk(16'(cyc < 1000), 16'h0001, "wait limit");
   endtask : wait_on
   task meas();
      @(posedge clk);
      meas_request <= 1'b1;
      @(posedge clk);
      meas_request <= 1'b0;
      s0 = samp_cnt;
      wait_on(1'b0);
      // the result register takes the average one edge after the valid pulse
      @(posedge clk);
      #1;
   endtask : meas
   task cal(input logic [7:0] sync, input logic pfe, input bit gated);
      wr(PCC_ADDR_CALIB_SYNC, sync);
      pfs_en <= pfe;
      @(posedge clk);
      calib_start <= 1'b1;
      @(posedge clk);
      calib_start <= 1'b0;
      s0 = samp_cnt;
      if (gated) begin
         repeat (60) @(posedge clk);
         fs_en <= 1'b1;
         #1;
         chk(16'(samp_cnt - s0), 16'h0000, "samples before frame");
         chk(calibrating, 1'b1, "busy before frame");
      end
      wait_on(1'b1);
      chk(16'(samp_cnt - s0), 16'h0009, "calibration samples");
      chk(calibrating, 1'b0, "idle after run");
      @(posedge clk);
      fs_en <= 1'b0;
   endtask : cal
   task test_done();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {reset, err_total, compares, samp_cnt, fs_cnt} = '0;
      reset = 1'b1;
      {reg_write, reg_read, calib_start, meas_request, pfs_en, cal_irq, fs_en} = '0;
      {reg_addr, reg_wdata, irq_events, level} = '0;
      diode_enable = 1'b1;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rd(PCC_ADDR_CALIB_CFG, PCC_CFG_RESET, "config reset");
      rd(PCC_ADDR_CALIB_SYNC, 8'h00, "sync reset");
      rd(PCC_ADDR_CALIB_STAT, 8'h00, "status reset");
      rd(PCC_ADDR_INTEN, 8'h00, "enable reset");
      rd(8'hdb, 8'h00, "unmapped read");
      // reserved bit 4 always written as 1
      cal(8'h00, 1'b0, 1'b0);
      chk(prox_offset, 9'h000, "offset for dark target");
      level <= 10'h155;
      for (int c = 0; c < 6; c++) begin
         wr(PCC_ADDR_CALIB_CFG, 8'h50 | 8'(c));
         meas();
         chk(16'(samp_cnt - s0), 16'(c > 4 ? 1 : 1 << c), "samples per result");
         chk(proximity_result, level, "averaged result");
      end
      cal(8'h01, 1'b0, 1'b1);
      chk(16'(cyc >= 320), 16'h0001, "every cycle synced");
      chk(prox_offset, 9'h1ff, "offset for bright target");
      cal(8'h00, 1'b1, 1'b1);
      chk(16'(cyc < 120), 16'h0001, "only first synced");
      wr(PCC_ADDR_CALIB_CFG, 8'h58);
      level <= 10'h000;
      meas();
      chk(prox_offset, 9'h1fe, "offset lowered");
      rd(PCC_ADDR_CALIB_STAT, 8'h04, "lowered flag set");
      wr(PCC_ADDR_CALIB_STAT, 8'h04);
      rd(PCC_ADDR_CALIB_STAT, 8'h00, "flag write one");
      meas();
      rd(PCC_ADDR_CALIB_STAT, 8'h04, "flag set again");
      wr(PCC_ADDR_CALIB_CFG, 8'h50);
      rd(PCC_ADDR_CALIB_STAT, 8'h00, "flag auto off");
      wr(PCC_ADDR_CALIB_CFG, 8'h58);
      diode_enable <= 1'b0;
      meas();
      rd(PCC_ADDR_CALIB_STAT, 8'h00, "diode off");
      wr(8'hdb, 8'hff);
      cal_irq <= 1'b1;
      rd(PCC_ADDR_CALIB_STAT, 8'h01, "done mirror");
      wr(PCC_ADDR_INTEN, 8'h08);
      cal_irq    <= 1'b0;
      irq_events <= 8'h08;
      rd(PCC_ADDR_CALIB_STAT, 8'h00, "done cleared");
      chk(irq_out, 1'b1, "enabled event");
      wr(PCC_ADDR_INTEN, 8'hff);
      irq_events <= 8'h02;
      rd(PCC_ADDR_INTEN, 8'hff, "enable readback");
      chk(irq_out, 1'b0, "style bit no event");
      chk(style, 1'b1, "style select");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule : testbench
